/* File: isp_flash_programmer.sv */
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "isp_regs.svh"

// Operation
// - enable bit 0 of chip_control, writes need the timed-access unlock
// - enable starts the RC timing oscillator, disable lets it stop
// - 16-bit address from high/low registers, data and command registers used
// - writing 1 to go starts an operation; trigger writes need unlock
// - program counter held during automation, released on completion
// - go is not stored; it acts only in the cycle of the trigger write
// - command: region bits 7:6, output enable 5, chip enable 4, op 3:0
// - fault when application code erases or programs application rom
// - fault when application code modifies loader rom with update disabled
// - fault when application code touches configuration bytes
// - fault when loader code modifies loader rom, or address oversize
// - fault when controlling code runs from external program memory
// - update enable bit 5 opens loader rom to application code
// - address high byte gives bits 15:8, resets to zero
// - address low byte gives bits 7:0, resets to zero
// - erase 0010, program 0001, read 0000; regions 00, 01, 11; both enables standby
// - page erase clears one 256-byte page, low address byte zero
// - data register written before program, holds read result after read
// - go bit always reads as zero
module isp_flash_programmer
	import isp_pkg::*;
#(
	parameter int ADDR_W = 12,
	parameter int ERASE_CYCLES = `ISP_ERASE_CYCLES,
	parameter int PROGRAM_CYCLES = `ISP_PROGRAM_CYCLES,
	parameter int READ_CYCLES = `ISP_READ_CYCLES,
	parameter int APP_BYTES = `ISP_APP_BYTES,
	parameter int LOADER_BYTES = `ISP_LOADER_BYTES
) (
	input logic aclk,
	input logic aresetn,
	input logic [ADDR_W-1:0] s_axi_awaddr,
	input logic s_axi_awvalid,
	output logic s_axi_awready,
	input logic [31:0] s_axi_wdata,
	input logic [3:0] s_axi_wstrb,
	input logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input logic s_axi_bready,
	input logic [ADDR_W-1:0] s_axi_araddr,
	input logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input logic s_axi_rready,
	input logic code_in_loader,
	input logic code_external,
	output logic cpu_hold,
	output logic rc_osc_enable,
	output logic [17:0] flash_addr,
	output logic [7:0] flash_wdata,
	input logic [7:0] flash_rdata,
	output logic flash_erase,
	output logic flash_program,
	output logic flash_read,
	output logic flash_pump_enable
);
	// ****************************************
	// state
	// ****************************************
	logic enable_reg, enable_next;
	logic loader_update_enable_reg, loader_update_enable_next;
	logic fault_reg, fault_next;
	logic [7:0] addr_low_reg, addr_low_next;
	logic [7:0] addr_high_reg, addr_high_next;
	logic [7:0] cmd_reg, cmd_next;
	logic [7:0] data_reg, data_next;
	isp_state_type state_reg, state_next;
	isp_opkind_type kind_reg, kind_next;
	isp_ta_type ta_reg, ta_next;
	logic [3:0] ta_count_reg, ta_count_next;
	logic bvalid_reg, bvalid_next;
	logic [1:0] bresp_reg, bresp_next;
	logic rvalid_reg, rvalid_next;
	logic [31:0] rdata_reg, rdata_next;
	logic [1:0] rresp_reg, rresp_next;
	logic [17:0] faddr_reg, faddr_next;
	logic [7:0] fwdata_reg, fwdata_next;
	logic start_op, abort_op, op_done, wr_fire, rd_fire, go_write, illegal;
	logic [7:0] widx, ridx, wbyte;
	logic [1:0] region;
	isp_opkind_type op_kind;

	assign widx = s_axi_awaddr[9:2];
	assign ridx = s_axi_araddr[9:2];
	assign wbyte = s_axi_wdata[7:0];
	assign region = cmd_reg[`ISP_CMD_REGION_MSB:`ISP_CMD_REGION_LSB];
	assign wr_fire = s_axi_awvalid && s_axi_wvalid && !bvalid_reg;
	assign rd_fire = s_axi_arvalid && !rvalid_reg;

	// ****************************************
	// helpers
	// ****************************************
	function automatic logic mapped(input logic [7:0] idx);
		mapped = (idx == `ISP_IDX_CHIP_CONTROL) || (idx == `ISP_IDX_TRIGGER) ||
			(idx == `ISP_IDX_ADDR_LOW) || (idx == `ISP_IDX_ADDR_HIGH) ||
			(idx == `ISP_IDX_DATA) || (idx == `ISP_IDX_COMMAND) ||
			(idx == `ISP_IDX_TIMED_ACCESS);
	endfunction

	// output/chip enable pair must agree with the op code, else refused as illegal
	function automatic isp_opkind_type decode_op(input logic [7:0] c);
		logic oe, ce;
		logic [3:0] op;
		oe = c[`ISP_CMD_OE_BIT];
		ce = c[`ISP_CMD_CE_BIT];
		op = c[`ISP_CMD_OP_MSB:`ISP_CMD_OP_LSB];
		decode_op = OPK_BAD;
		if (!ce && oe && op == `ISP_OP_ERASE) decode_op = OPK_ERASE;
		if (!ce && oe && op == `ISP_OP_PROGRAM) decode_op = OPK_PROGRAM;
		if (!ce && !oe && op == `ISP_OP_READ) decode_op = OPK_READ;
	endfunction

	function automatic logic access_illegal(input logic [1:0] reg_sel,
		input isp_opkind_type k, input logic [15:0] a, input logic from_loader,
		input logic upd_en, input logic ext);
		logic modify;
		logic [31:0] wide;
		modify = (k == OPK_ERASE) || (k == OPK_PROGRAM);
		wide = {16'h0000, a};
		access_illegal = ext || (k == OPK_BAD);
		if (!from_loader) begin
			if (reg_sel == `ISP_REGION_APP && modify) access_illegal = 1'b1;
			if (reg_sel == `ISP_REGION_LOADER && modify && !upd_en)
				access_illegal = 1'b1;
			if (reg_sel == `ISP_REGION_CONFIG) access_illegal = 1'b1;
		end else if (reg_sel == `ISP_REGION_LOADER && modify) begin
			access_illegal = 1'b1;
		end
		unique case (reg_sel)
			`ISP_REGION_APP: if (wide >= 32'(APP_BYTES)) access_illegal = 1'b1;
			`ISP_REGION_LOADER: if (wide >= 32'(LOADER_BYTES)) access_illegal = 1'b1;
			`ISP_REGION_CONFIG: begin
				if (k != OPK_ERASE && a > `ISP_CONFIG_LAST) access_illegal = 1'b1;
			end
			default: access_illegal = 1'b1;
		endcase
	endfunction

	assign op_kind = decode_op(cmd_reg);
	assign go_write = wr_fire && s_axi_wstrb[0] && widx == `ISP_IDX_TRIGGER &&
		wbyte[`ISP_GO_BIT] && ta_reg == TA_OPEN && enable_reg && state_reg == ST_IDLE;
	assign illegal = access_illegal(region, op_kind, {addr_high_reg, addr_low_reg},
		code_in_loader, loader_update_enable_reg, code_external);
	// standby command (both enables set) starts no operation but still sets the fault flag
	assign start_op = go_write && !(cmd_reg[`ISP_CMD_OE_BIT] && cmd_reg[`ISP_CMD_CE_BIT]) &&
		!illegal;
	assign abort_op = state_reg == ST_BUSY && code_external;

	// ****************************************
	// registers, bus and sequencer
	// ****************************************
	always_comb begin
		enable_next = enable_reg;
		loader_update_enable_next = loader_update_enable_reg;
		fault_next = fault_reg;
		addr_low_next = addr_low_reg;
		addr_high_next = addr_high_reg;
		cmd_next = cmd_reg;
		data_next = data_reg;
		state_next = state_reg;
		kind_next = kind_reg;
		ta_next = ta_reg;
		ta_count_next = ta_count_reg;
		faddr_next = faddr_reg;
		fwdata_next = fwdata_reg;
		bvalid_next = bvalid_reg && !s_axi_bready;
		bresp_next = bresp_reg;
		rvalid_next = rvalid_reg && !s_axi_rready;
		rdata_next = rdata_reg;
		rresp_next = rresp_reg;
		// unlock window closes by itself after a few cycles
		if (ta_reg == TA_OPEN) begin
			ta_count_next = ta_count_reg - 4'h1;
			if (ta_count_reg == 4'h0) ta_next = TA_LOCKED;
		end
		if (wr_fire) begin
			bvalid_next = 1'b1;
			bresp_next = mapped(widx) ? `ISP_RESP_OKAY : `ISP_RESP_DECERR;
			if (s_axi_wstrb[0]) begin
				unique case (widx)
					`ISP_IDX_TIMED_ACCESS: begin
						ta_next = TA_LOCKED;
						if (wbyte == `ISP_TA_KEY1) ta_next = TA_HALF;
						if (wbyte == `ISP_TA_KEY2 && ta_reg == TA_HALF) begin
							ta_next = TA_OPEN;
							ta_count_next = `ISP_TA_WINDOW;
						end
					end
					`ISP_IDX_CHIP_CONTROL: begin
						ta_next = TA_LOCKED;
						if (ta_reg == TA_OPEN) begin
							enable_next = wbyte[`ISP_CC_ENABLE_BIT];
							loader_update_enable_next = wbyte[`ISP_CC_LOADER_UPDATE_ENABLE_BIT];
							if (!wbyte[`ISP_CC_FAULT_BIT]) fault_next = 1'b0;
						end
					end
					`ISP_IDX_TRIGGER: ta_next = TA_LOCKED;
					`ISP_IDX_ADDR_LOW: addr_low_next = wbyte;
					`ISP_IDX_ADDR_HIGH: addr_high_next = wbyte;
					`ISP_IDX_DATA: data_next = wbyte;
					`ISP_IDX_COMMAND: cmd_next = wbyte;
					default: ;
				endcase
			end
		end
		if (rd_fire) begin
			rvalid_next = 1'b1;
			rresp_next = mapped(ridx) ? `ISP_RESP_OKAY : `ISP_RESP_DECERR;
			rdata_next = 32'h0000_0000;
			unique case (ridx)
				`ISP_IDX_CHIP_CONTROL: begin
					rdata_next[`ISP_CC_ENABLE_BIT] = enable_reg;
					rdata_next[`ISP_CC_LOADER_UPDATE_ENABLE_BIT] = loader_update_enable_reg;
					rdata_next[`ISP_CC_FAULT_BIT] = fault_reg;
				end
				`ISP_IDX_ADDR_LOW: rdata_next[7:0] = addr_low_reg;
				`ISP_IDX_ADDR_HIGH: rdata_next[7:0] = addr_high_reg;
				`ISP_IDX_DATA: rdata_next[7:0] = data_reg;
				`ISP_IDX_COMMAND: rdata_next[7:0] = cmd_reg;
				default: ;
			endcase
		end
		// hardware set comes after the software clear, so a clash keeps the flag
		if (go_write && illegal) fault_next = 1'b1;
		if (start_op) begin
			state_next = ST_BUSY;
			kind_next = op_kind;
			faddr_next = {region, addr_high_reg, addr_low_reg};
			if (op_kind == OPK_ERASE) faddr_next[7:0] = `ISP_PAGE_LOW;
			fwdata_next = data_reg;
		end
		if (abort_op) begin
			fault_next = 1'b1;
			state_next = ST_IDLE;
		end else if (state_reg == ST_BUSY && op_done) begin
			state_next = ST_IDLE;
			if (kind_reg == OPK_READ) data_next = flash_rdata;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			enable_reg <= 1'b0;
			loader_update_enable_reg <= 1'b0;
			fault_reg <= 1'b0;
			addr_low_reg <= `ISP_RESET_BYTE;
			addr_high_reg <= `ISP_RESET_BYTE;
			cmd_reg <= `ISP_RESET_BYTE;
			data_reg <= `ISP_RESET_BYTE;
			state_reg <= ST_IDLE;
			kind_reg <= OPK_READ;
			ta_reg <= TA_LOCKED;
			ta_count_reg <= 4'h0;
			faddr_reg <= 18'h0_0000;
			fwdata_reg <= `ISP_RESET_BYTE;
			bvalid_reg <= 1'b0;
			bresp_reg <= `ISP_RESP_OKAY;
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h0000_0000;
			rresp_reg <= `ISP_RESP_OKAY;
		end else begin
			enable_reg <= enable_next;
			loader_update_enable_reg <= loader_update_enable_next;
			fault_reg <= fault_next;
			addr_low_reg <= addr_low_next;
			addr_high_reg <= addr_high_next;
			cmd_reg <= cmd_next;
			data_reg <= data_next;
			state_reg <= state_next;
			kind_reg <= kind_next;
			ta_reg <= ta_next;
			ta_count_reg <= ta_count_next;
			faddr_reg <= faddr_next;
			fwdata_reg <= fwdata_next;
			bvalid_reg <= bvalid_next;
			bresp_reg <= bresp_next;
			rvalid_reg <= rvalid_next;
			rdata_reg <= rdata_next;
			rresp_reg <= rresp_next;
		end
	end

	// timing counted on aclk; the rc oscillator only needs to run while enabled
	isp_op_timer #(
		.ERASE_CYCLES(ERASE_CYCLES),
		.PROGRAM_CYCLES(PROGRAM_CYCLES),
		.READ_CYCLES(READ_CYCLES)
	) u_timer (
		.aclk(aclk),
		.aresetn(aresetn),
		.start(start_op),
		.abort(abort_op),
		.kind(op_kind),
		.done(op_done)
	);

	// ****************************************
	// outputs
	// ****************************************
	assign s_axi_awready = wr_fire;
	assign s_axi_wready = wr_fire;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_arready = !rvalid_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata = rdata_reg;
	assign s_axi_rresp = rresp_reg;
	assign cpu_hold = state_reg == ST_BUSY;
	assign rc_osc_enable = enable_reg;
	assign flash_addr = faddr_reg;
	assign flash_wdata = fwdata_reg;
	assign flash_erase = cpu_hold && kind_reg == OPK_ERASE;
	assign flash_program = cpu_hold && kind_reg == OPK_PROGRAM;
	assign flash_read = cpu_hold && kind_reg == OPK_READ;
	assign flash_pump_enable = flash_erase || flash_program;

	// ****************************************
	// checks
	// ****************************************
	sequence s_legal_go;
		start_op;
	endsequence
	sequence s_bad_go;
		go_write && illegal;
	endsequence

	property p_go_holds_cpu;
		@(posedge aclk) disable iff (!aresetn) s_legal_go |=> cpu_hold;
	endproperty
	a_go_holds_cpu: assert property (p_go_holds_cpu) else $error("no hold after go");

	property p_done_releases;
		@(posedge aclk) disable iff (!aresetn) cpu_hold && op_done |=> !cpu_hold;
	endproperty
	a_done_releases: assert property (p_done_releases) else $error("hold stuck");

	property p_bad_sets_fault;
		@(posedge aclk) disable iff (!aresetn) s_bad_go |=> fault_reg && !cpu_hold;
	endproperty
	a_bad_sets_fault: assert property (p_bad_sets_fault) else $error("fault missed");

	property p_bad_no_flash;
		@(posedge aclk) disable iff (!aresetn)
			(s_bad_go and !cpu_hold) |=> !flash_erase && !flash_program;
	endproperty
	a_bad_no_flash: assert property (p_bad_no_flash) else $error("flash touched");

	property p_disabled_no_start;
		@(posedge aclk) disable iff (!aresetn) !enable_reg |-> !start_op;
	endproperty
	a_disabled_no_start: assert property (p_disabled_no_start) else $error("start off");

	property p_go_reads_zero;
		@(posedge aclk) disable iff (!aresetn)
			rd_fire && ridx == `ISP_IDX_TRIGGER |=> s_axi_rdata == 32'h0000_0000;
	endproperty
	a_go_reads_zero: assert property (p_go_reads_zero) else $error("go reads one");

	property p_read_result;
		@(posedge aclk) disable iff (!aresetn)
			cpu_hold && op_done && kind_reg == OPK_READ && !abort_op
			|=> data_reg == $past(flash_rdata);
	endproperty
	a_read_result: assert property (p_read_result) else $error("read lost");

	property p_erase_page;
		@(posedge aclk) disable iff (!aresetn) flash_erase |-> flash_addr[7:0] == 8'h00;
	endproperty
	a_erase_page: assert property (p_erase_page) else $error("erase not paged");

	property p_osc_on;
		@(posedge aclk) disable iff (!aresetn) cpu_hold |-> rc_osc_enable;
	endproperty
	a_osc_on: assert property (p_osc_on) else $error("osc off in op");

	property p_addr_reset;
		@(posedge aclk) !aresetn |=> addr_low_reg == 8'h00 && addr_high_reg == 8'h00;
	endproperty
	a_addr_reset: assert property (p_addr_reset) else $error("addr reset");
endmodule

/* File: isp_regs.svh */
`ifndef ISP_REGS_SVH
`define ISP_REGS_SVH

// ****************************************
// register indices, byte address is four times the index
// ****************************************
`define ISP_IDX_CHIP_CONTROL 8'h9F
`define ISP_IDX_TRIGGER 8'hA4
`define ISP_IDX_ADDR_LOW 8'hA6
`define ISP_IDX_ADDR_HIGH 8'hA7
`define ISP_IDX_DATA 8'hAE
`define ISP_IDX_COMMAND 8'hAF
`define ISP_IDX_TIMED_ACCESS 8'hC7

// ****************************************
// fields
// ****************************************
`define ISP_CC_ENABLE_BIT 0
`define ISP_CC_LOADER_UPDATE_ENABLE_BIT 5
`define ISP_CC_FAULT_BIT 6
`define ISP_GO_BIT 0
`define ISP_CMD_REGION_MSB 7
`define ISP_CMD_REGION_LSB 6
`define ISP_CMD_OE_BIT 5
`define ISP_CMD_CE_BIT 4
`define ISP_CMD_OP_MSB 3
`define ISP_CMD_OP_LSB 0
`define ISP_RESET_BYTE 8'h00

// ****************************************
// command codes and regions
// ****************************************
`define ISP_OP_ERASE 4'h2
`define ISP_OP_PROGRAM 4'h1
`define ISP_OP_READ 4'h0
`define ISP_REGION_APP 2'h0
`define ISP_REGION_LOADER 2'h1
`define ISP_REGION_CONFIG 2'h3
`define ISP_CONFIG_LAST 16'h0003
`define ISP_PAGE_LOW 8'h00

// ****************************************
// unlock sequence and bus answers
// ****************************************
`define ISP_TA_KEY1 8'hAA
`define ISP_TA_KEY2 8'h55
`define ISP_TA_WINDOW 4'h4
`define ISP_RESP_OKAY 2'h0
`define ISP_RESP_DECERR 2'h3

// ****************************************
// timing and memory sizes
// ****************************************
`define ISP_CLK_FREQ_HZ 32'h0098_9680
`define ISP_RC_FREQ_HZ 32'h0151_8000
`define ISP_ERASE_CYCLES 32'h0000_C350
`define ISP_PROGRAM_CYCLES 32'h0000_012C
`define ISP_READ_CYCLES 32'h0000_0002
`define ISP_APP_BYTES 32'h0001_0000
`define ISP_LOADER_BYTES 32'h0000_1000

`endif

/* File: isp_pkg.sv */
package isp_pkg;
	typedef enum {ST_IDLE, ST_BUSY} isp_state_type;
	typedef enum {TA_LOCKED, TA_HALF, TA_OPEN} isp_ta_type;
	typedef enum logic [1:0] {OPK_READ, OPK_PROGRAM, OPK_ERASE, OPK_BAD} isp_opkind_type;
endpackage

/* File: isp_op_timer.sv */
`timescale 1ns/1ps
`include "isp_regs.svh"

module isp_op_timer
	import isp_pkg::*;
#(
	parameter int ERASE_CYCLES = `ISP_ERASE_CYCLES,
	parameter int PROGRAM_CYCLES = `ISP_PROGRAM_CYCLES,
	parameter int READ_CYCLES = `ISP_READ_CYCLES
) (
	input logic aclk,
	input logic aresetn,
	input logic start,
	input logic abort,
	input isp_opkind_type kind,
	output logic done
);
	logic [31:0] count_reg;
	logic [31:0] count_next;
	logic done_reg;
	logic done_next;

	// ****************************************
	// operation length, at least one cycle each
	// ****************************************
	function automatic logic [31:0] op_length(input isp_opkind_type k);
		logic [31:0] n;
		unique case (k)
			OPK_ERASE: n = 32'(ERASE_CYCLES);
			OPK_PROGRAM: n = 32'(PROGRAM_CYCLES);
			default: n = 32'(READ_CYCLES);
		endcase
		op_length = (n == 32'h0000_0000) ? 32'h0000_0001 : n;
	endfunction

	always_comb begin
		count_next = count_reg;
		done_next = 1'b0;
		if (abort) begin
			count_next = 32'h0000_0000;
		end else if (start) begin
			count_next = op_length(kind);
		end else if (count_reg != 32'h0000_0000) begin
			count_next = count_reg - 32'h0000_0001;
			done_next = (count_reg == 32'h0000_0001);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			count_reg <= 32'h0000_0000;
			done_reg <= 1'b0;
		end else begin
			count_reg <= count_next;
			done_reg <= done_next;
		end
	end

	assign done = done_reg;
endmodule

/* File: isfp_flash_model.sv */
`timescale 1ns/1ps

// ****************************************
// flash array behind the programmer
// ****************************************
module isfp_flash_model (
	input wire logic aclk,
	input wire logic [17:0] flash_addr,
	input wire logic [7:0] flash_wdata,
	input wire logic flash_erase,
	input wire logic flash_program,
	input wire logic flash_read,
	output logic [7:0] flash_rdata
);
	logic [7:0] mem [int];
	logic prog_d = 1'b0;
	logic erase_d = 1'b0;
	initial flash_rdata = 8'h00;
	always @(posedge aclk) begin
		prog_d <= flash_program;
		erase_d <= flash_erase;
		// cells only go from one to zero when programmed
		if (flash_program && !prog_d) begin
			mem[int'(flash_addr)] = (mem.exists(int'(flash_addr)) ?
				mem[int'(flash_addr)] : 8'hFF) & flash_wdata;
		end
		if (flash_erase && !erase_d) begin
			for (int i = 0; i < 256; i++) begin
				mem.delete(int'({flash_addr[17:8], i[7:0]}));
			end
		end
		// idle bus toggles, so a stale byte is never mistaken for data
		if (flash_read) begin
			flash_rdata <= mem.exists(int'(flash_addr)) ? mem[int'(flash_addr)] : 8'hFF;
		end else begin
			flash_rdata <= ~flash_rdata;
		end
	end
endmodule

/* File: test_in_system_flash_programmer.sv */
`timescale 1ns/1ps
`include "isp_regs.svh"

module test_in_system_flash_programmer;
	localparam int ERASE_N = 8;
	localparam int PROG_N = 4;
	localparam int READ_N = 2;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [11:0] awaddr = 12'h000;
	logic [11:0] araddr = 12'h000;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = 32'h0000_0000;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic code_in_loader = 1'b0, code_external = 1'b0;
	logic cpu_hold, rc_osc_enable, flash_erase, flash_program, flash_read, flash_pump_enable;
	logic [17:0] flash_addr;
	logic [7:0] flash_wdata, flash_rdata, dat;
	logic [33:0] notes [$];
	logic [21:0] seen_sig = 22'h0;
	logic hold_prev = 1'b0;
	int hold_cnt = 0;
	int fails = 0;
	int n_compared = 0;
	int seed = 32'h7dc5_287f;
	// loader code, external code, command, address high
	logic [17:0] bad_cases [6] = '{{2'b00, 8'h21, 8'h01}, {2'b00, 8'h61, 8'h01},
		{2'b00, 8'hC0, 8'h00}, {2'b10, 8'h61, 8'h01}, {2'b10, 8'h40, 8'h10},
		{2'b11, 8'h21, 8'h01}};

	isp_flash_programmer #(.ERASE_CYCLES(ERASE_N), .PROGRAM_CYCLES(PROG_N),
		.READ_CYCLES(READ_N)) dut_u (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .code_in_loader(code_in_loader),
		.code_external(code_external), .cpu_hold(cpu_hold), .rc_osc_enable(rc_osc_enable),
		.flash_addr(flash_addr), .flash_wdata(flash_wdata), .flash_rdata(flash_rdata),
		.flash_erase(flash_erase), .flash_program(flash_program), .flash_read(flash_read),
		.flash_pump_enable(flash_pump_enable));
	isfp_flash_model flash_u (.aclk(aclk), .flash_addr(flash_addr),
		.flash_wdata(flash_wdata), .flash_erase(flash_erase),
		.flash_program(flash_program), .flash_read(flash_read), .flash_rdata(flash_rdata));

	// ****************************************
	// reporting
	// ****************************************
	task automatic check(input string what, input logic [33:0] seen, input logic [33:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fails++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic conclude();
		if (fails == 0 && n_compared > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// ****************************************
	// bus master and watchers
	// ****************************************
	task automatic wr(input logic [7:0] idx, input logic [7:0] val);
		@(posedge aclk);
		awaddr <= {2'b00, idx, 2'b00};
		wdata <= {24'h00_0000, val};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		// no cycle limit here: only the watchdog may end a wait
		do @(posedge aclk); while (!(awready === 1'b1 && wready === 1'b1));
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		bready <= 1'b1;
		do @(posedge aclk); while (bvalid !== 1'b1);
		check("axi bresp", bresp, `ISP_RESP_OKAY);
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] idx, input logic [7:0] exp,
		input logic [1:0] resp = `ISP_RESP_OKAY);
		notes.push_back({resp, 24'h00_0000, exp});
		@(posedge aclk);
		araddr <= {2'b00, idx, 2'b00};
		arvalid <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		rready <= 1'b1;
		do @(posedge aclk); while (rvalid !== 1'b1);
		rready <= 1'b0;
	endtask
	task automatic unlocked(input logic [7:0] idx, input logic [7:0] val);
		wr(`ISP_IDX_TIMED_ACCESS, `ISP_TA_KEY1);
		wr(`ISP_IDX_TIMED_ACCESS, `ISP_TA_KEY2);
		wr(idx, val);
	endtask
	always @(posedge aclk) begin
		if (rvalid === 1'b1 && rready === 1'b1) begin
			check("axi read", {rresp, rdata}, notes.size() > 0 ? notes.pop_front() : 34'h0);
		end
		if (cpu_hold === 1'b1) begin
			hold_cnt <= hold_cnt + 1;
			if (hold_prev !== 1'b1) begin
				seen_sig <= {flash_pump_enable, flash_erase, flash_program, flash_read, flash_addr};
			end
		end
		hold_prev <= cpu_hold;
	end

	// one full triggered operation, then the hold length and flags
	task automatic op(input logic ldr, input logic ext, input logic [7:0] cmd,
		input logic [7:0] ah, input logic [7:0] al, input logic [7:0] d,
		input int exp_hold, input logic [7:0] exp_cc);
		int i;
		logic [3:0] kind;
		int base;
		kind = (cmd[3:0] == `ISP_OP_ERASE) ? 4'b1100 :
			(cmd[3:0] == `ISP_OP_PROGRAM) ? 4'b1010 : 4'b0001;
		code_in_loader <= ldr;
		code_external <= ext;
		wr(`ISP_IDX_ADDR_HIGH, ah);
		wr(`ISP_IDX_ADDR_LOW, al);
		wr(`ISP_IDX_DATA, d);
		wr(`ISP_IDX_COMMAND, cmd);
		// hold count only grows in the watcher; measure from here
		base = hold_cnt;
		unlocked(`ISP_IDX_TRIGGER, 8'h01);
		for (i = 0; i < 40; i++) begin
			@(posedge aclk);
			if (hold_cnt > base && cpu_hold !== 1'b1) break;
		end
		check("hold cycles", hold_cnt - base, exp_hold);
		if (exp_hold > 0) begin
			check("flash signals", seen_sig, {kind, cmd[7:6], ah, kind[2] ? 8'h00 : al});
		end
		rd(`ISP_IDX_CHIP_CONTROL, exp_cc);
		rd(`ISP_IDX_TRIGGER, 8'h00);
		code_external <= 1'b0;
	endtask

	// ****************************************
	// scenarios
	// ****************************************
	initial forever #50 aclk = ~aclk;
	initial begin
		#600000;
		fails++;
		conclude();
	end
	initial begin
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		rd(`ISP_IDX_CHIP_CONTROL, 8'h00);
		rd(`ISP_IDX_ADDR_LOW, `ISP_RESET_BYTE);
		rd(`ISP_IDX_ADDR_HIGH, `ISP_RESET_BYTE);
		rd(`ISP_IDX_COMMAND, `ISP_RESET_BYTE);
		rd(8'h10, 8'h00, `ISP_RESP_DECERR);
		wr(`ISP_IDX_CHIP_CONTROL, 8'h01);
		rd(`ISP_IDX_CHIP_CONTROL, 8'h00);
		op(1'b1, 1'b0, 8'h21, 8'h01, 8'h23, 8'h00, 0, 8'h00);
		unlocked(`ISP_IDX_CHIP_CONTROL, 8'h01);
		rd(`ISP_IDX_CHIP_CONTROL, 8'h01);
		check("osc on", rc_osc_enable, 1'b1);
		dat = 8'($random(seed));
		op(1'b1, 1'b0, 8'h21, 8'h01, 8'h23, dat, PROG_N + 1, 8'h01);
		op(1'b1, 1'b0, 8'h00, 8'h01, 8'h23, 8'h00, READ_N + 1, 8'h01);
		rd(`ISP_IDX_DATA, dat);
		op(1'b1, 1'b0, 8'h22, 8'h01, 8'h23, 8'h00, ERASE_N + 1, 8'h01);
		op(1'b1, 1'b0, 8'h00, 8'h01, 8'h23, 8'h00, READ_N + 1, 8'h01);
		rd(`ISP_IDX_DATA, 8'hFF);
		foreach (bad_cases[k]) begin
			op(bad_cases[k][17], bad_cases[k][16], bad_cases[k][15:8], bad_cases[k][7:0],
				8'h23, 8'h00, 0, 8'h41);
			unlocked(`ISP_IDX_CHIP_CONTROL, 8'h01);
			rd(`ISP_IDX_CHIP_CONTROL, 8'h01);
		end
		op(1'b1, 1'b0, 8'h00, 8'h01, 8'h23, 8'h00, READ_N + 1, 8'h01);
		rd(`ISP_IDX_DATA, 8'hFF);
		unlocked(`ISP_IDX_CHIP_CONTROL, 8'h21);
		op(1'b0, 1'b0, 8'h61, 8'h01, 8'h23, dat, PROG_N + 1, 8'h21);
		op(1'b0, 1'b0, 8'h40, 8'h01, 8'h23, 8'h00, READ_N + 1, 8'h21);
		rd(`ISP_IDX_DATA, dat);
		unlocked(`ISP_IDX_CHIP_CONTROL, 8'h00);
		check("osc off", rc_osc_enable, 1'b0);
		op(1'b1, 1'b0, 8'h21, 8'h01, 8'h23, dat, 0, 8'h00);
		conclude();
	end
endmodule
